// ### bench/tb_timer3_capture_unit.sv
`timescale 1ns/10ps
`include "tcu_defs.svh"

module tb_timer3_capture_unit;
   logic        aclk;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  wstrb   = 4'h0;
   logic [2:0]  prot    = 3'h0;
   logic [31:0] rdata, rd;
   logic [1:0]  bresp, rresp, rs;
   logic [3:0]  pin;
   logic        ext_clk, awready, wready, bvalid, arready, rvalid, irq;
   logic [15:0] cnt, v, v2;
   int          fail_count, comparisons, cycles, p;

   tcu_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(prot),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(prot), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .snap_input_pin(pin), .external_count_clock(ext_clk),
      .irq(irq));

   tcu_pin_model pins (.aclk(aclk), .pin(pin), .ext_clk(ext_clk));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd8(input logic [7:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : rd8

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      rd8(a);
      check(rd, {24'h0, exp});
      check(rs, `TCU_RESP_OKAY);
   endtask : rdc

   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(a + 8'h04, d[15:8]);
   endtask : wr16

   task automatic rd16(input logic [7:0] a);
      rd8(a);
      cnt[7:0] = rd[7:0];
      rd8(a + 8'h04);
      cnt[15:8] = rd[7:0];
   endtask : rd16

   initial begin
      void'($urandom(32'h4bfc));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values across the map, then unmapped places
      for (int a = 0; a <= 32'h3C; a += 4) begin
         rdc(8'(a), 8'h00);
      end
      rd8(8'h40);
      check(rd, 32'h0);
      check(rs, `TCU_RESP_SLVERR);
      wr(8'h41, 8'h5A);
      check(rs, `TCU_RESP_SLVERR);
      // Count load, strobe-less write, stopped counter
      v = 16'($urandom);
      wr16(`TCU_OFS_CNT_LO, v);
      wr(`TCU_OFS_CNT_LO, ~v[7:0], 4'h0);
      check(rs, `TCU_RESP_OKAY);
      wr(`TCU_OFS_CTRL, 8'h02);
      pins.ext_falls(3);
      repeat (8) @(posedge aclk);
      rd16(`TCU_OFS_CNT_LO);
      check(cnt, v);
      rdc(`TCU_OFS_STAT, 8'h00);
      // Free run through all ones on external edges
      v = 16'hFFFF - 16'($urandom % 3);
      wr16(`TCU_OFS_CNT_LO, v);
      wr(`TCU_OFS_MASK, 8'h01);
      wr(`TCU_OFS_CTRL, 8'h07);
      pins.ext_falls(3);
      repeat (8) @(posedge aclk);
      rd16(`TCU_OFS_CNT_LO);
      check(cnt, 16'(v + 16'h0003));
      check(irq, 1'b1);
      wr(`TCU_OFS_MASK, 8'h00);
      repeat (2) @(posedge aclk);
      check(irq, 1'b0);
      rdc(`TCU_OFS_STAT, 8'h01);
      // Period register ends the count
      p = 2 + $urandom % 4;
      wr16(`TCU_OFS_SNAP_BASE, 16'(p));
      wr16(`TCU_OFS_CNT_LO, 16'h0000);
      wr(`TCU_OFS_CTRL, 8'h03);
      pins.ext_falls(p);
      repeat (8) @(posedge aclk);
      rd16(`TCU_OFS_CNT_LO);
      check(cnt, 16'(p));
      rdc(`TCU_OFS_STAT, 8'h00);
      pins.ext_falls(1);
      repeat (8) @(posedge aclk);
      rd16(`TCU_OFS_CNT_LO);
      check(cnt, 16'h0000);
      rdc(`TCU_OFS_STAT, 8'h01);
      // Instruction cycle source: about 403 core clocks of running
      wr16(`TCU_OFS_CNT_LO, 16'h0000);
      wr(`TCU_OFS_CTRL, 8'h05);
      repeat (400) @(posedge aclk);
      wr(`TCU_OFS_CTRL, 8'h04);
      rd16(`TCU_OFS_CNT_LO);
      check(cnt >= 16'h0063 && cnt <= 16'h0066, 1'b1);
      rd8(`TCU_OFS_STAT);
      // Captures, period mode first
      wr(`TCU_OFS_CTRL, 8'h00);
      wr(`TCU_OFS_EDGE, 8'hE4);
      wr(`TCU_OFS_MASK, 8'h1E);
      v = 16'($urandom);
      wr16(`TCU_OFS_CNT_LO, v);
      pins.pulse(0, 1);
      repeat (8) @(posedge aclk);
      rdc(`TCU_OFS_STAT, 8'h00);
      wr(`TCU_OFS_CTRL, 8'h04);
      pins.pulse(0, 1);
      pins.pulse(1, 1);
      pins.pulse(2, 3);
      pins.pulse(3, 15);
      repeat (8) @(posedge aclk);
      for (int i = 0; i < 4; i++) begin
         wr(`TCU_OFS_IRQC, 8'(i));
         repeat (2) @(posedge aclk);
         check(irq, i == 1);
      end
      rdc(`TCU_OFS_STAT, 8'h06);
      pins.pulse(2, 1);
      pins.pulse(3, 1);
      repeat (8) @(posedge aclk);
      rdc(`TCU_OFS_STAT, 8'h18);
      // Overrun keeps the unread value
      v2 = ~v;
      wr16(`TCU_OFS_CNT_LO, v2);
      pins.pulse(1, 1);
      repeat (8) @(posedge aclk);
      for (int c = 0; c < 4; c++) begin
         rd16(8'(`TCU_OFS_SNAP_BASE + 8 * c));
         check(cnt, v);
      end
      rdc(`TCU_OFS_OVF, 8'h02);
      rd16(8'h10);
      rdc(`TCU_OFS_OVF, 8'h00);
      pins.pulse(1, 1);
      repeat (8) @(posedge aclk);
      rd16(8'h10);
      check(cnt, v2);
      rd8(`TCU_OFS_STAT);
      // Select change keeps the prescaler count
      pins.pulse(2, 2);
      repeat (8) @(posedge aclk);
      wr(`TCU_OFS_EDGE, 8'hC4);
      wr(`TCU_OFS_EDGE, 8'hE4);
      pins.pulse(2, 2);
      repeat (8) @(posedge aclk);
      rdc(`TCU_OFS_STAT, 8'h08);
      summarize();
   end
endmodule : tb_timer3_capture_unit

// ### bench/tcu_pin_model.sv
`timescale 1ns/10ps

module tcu_pin_model (
   input  wire logic  aclk,
   output logic [3:0] pin,
   output logic       ext_clk
);
   // Pins idle low, count clock idles high between bursts
   initial begin
      pin     = 4'h0;
      ext_clk = 1'b1;
   end

   // Whole pulses with random width, prompt or slow
   task automatic pulse(input int ch, input int n);
      for (int i = 0; i < 2 * n; i++) begin
         repeat (2 + $urandom % 4) @(posedge aclk);
         pin[ch] <= ~pin[ch];
      end
   endtask : pulse

   // Ends high, so n falling edges
   task automatic ext_falls(input int n);
      for (int i = 0; i < 2 * n; i++) begin
         repeat (3 + $urandom % 3) @(posedge aclk);
         ext_clk <= ~ext_clk;
      end
   endtask : ext_falls
endmodule : tcu_pin_model

// ### hw/tcu_snap_chan.sv
`timescale 1ns/10ps
`include "tcu_defs.svh"

module tcu_snap_chan
   import tcu_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       snap_input_pin,
   input  wire logic [1:0] edge_sel,
   output logic            snap_event
);

   tcu_chan_s c_q;
   tcu_chan_s c_d;
   logic      rise;
   logic      fall;

   assign rise = c_q.pin_s2 & ~c_q.pin_prev;
   assign fall = ~c_q.pin_s2 & c_q.pin_prev;

   always_comb begin
      c_d          = c_q;
      c_d.pin_s1   = snap_input_pin;                  // see RULE_15
      c_d.pin_s2   = c_q.pin_s1;
      c_d.pin_prev = c_q.pin_s2;
      // Prescaler free-runs on rising edges; select changes leave it alone
      if (rise) begin
         c_d.psc = c_q.psc + 4'h1;                    // see RULE_13
      end
      case (edge_sel)                                 // see RULE_11
         `TCU_EDGE_FALL: c_d.ev = fall;
         `TCU_EDGE_RISE: c_d.ev = rise;
         `TCU_EDGE_4TH:  c_d.ev = rise && (c_q.psc[1:0] == `TCU_PSC_4TH_LAST);
         `TCU_EDGE_16TH: c_d.ev = rise && (c_q.psc == `TCU_PSC_16TH_LAST);
         default:        c_d.ev = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c_q <= '0;
      end else begin
         c_q <= c_d;
      end
   end

   assign snap_event = c_q.ev;

   a_psc_hold: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_13
      !rise |=> $stable(c_q.psc))
      else $error("prescaler moved without a rising edge");

   a_rise_event: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_11
      (rise && edge_sel == `TCU_EDGE_RISE) |=> c_q.ev)
      else $error("rising edge select missed an event");

endmodule : tcu_snap_chan

// ### hw/tcu_tick_gen.sv
`timescale 1ns/10ps
`include "tcu_defs.svh"

module tcu_tick_gen
   import tcu_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic external_count_clock,
   output logic      icyc,
   output logic      efall
);

   tcu_tick_s t_q;
   tcu_tick_s t_d;

   always_comb begin
      t_d          = t_q;
      t_d.phase    = t_q.phase + 2'h1;
      t_d.icyc     = (t_q.phase == `TCU_ICYC_LAST); // see RULE_02
      t_d.ext_s1   = external_count_clock;
      t_d.ext_s2   = t_q.ext_s1;
      t_d.ext_prev = t_q.ext_s2;
      t_d.efall    = t_q.ext_prev & ~t_q.ext_s2;    // see RULE_03
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t_q <= '0;
      end else begin
         t_q <= t_d;
      end
   end

   assign icyc  = t_q.icyc;
   assign efall = t_q.efall;

   a_icyc_space: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_02
      t_q.icyc |=> !t_q.icyc [*3] ##1 t_q.icyc)
      else $error("instruction tick not every fourth clock");

endmodule : tcu_tick_gen

// ### hw/tcu_top.sv
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "tcu_defs.svh"

// Function
// RULE_01: Counter is 16-bit up counter, reached as high and low byte registers.
// RULE_02: Source select zero advances counter once per four core clocks.
// RULE_03: Source select one advances counter on external clock falling edges.
// RULE_04: Counter and its wrap flag only move while run is set.
// RULE_05: Mode bit clear makes channel one storage the period register.
// RULE_06: Period mode: count to period, then zero on next tick, set wrap flag.
// RULE_07: Period mode: channel one never captures, never sets its flag.
// RULE_08: Four channel mode: free run to all ones, wrap to zero, set flag.
// RULE_09: Wrap flag sticks until software clears it; enable bit masks it.
// RULE_10: Four channels, each pin copies full 16-bit count on its event.
// RULE_11: Two-bit select: falling, rising, every fourth or sixteenth rising edge.
// RULE_12: Capture sets flag; irq needs enable, peripheral enable, no global disable.
// RULE_13: Select change keeps prescaler; only reset clears it.
// RULE_14: Capture stays active whatever the pin's port use.
// RULE_15: Capture pins pass a synchroniser before edge detection.
// RULE_16: Event on unread channel sets hidden overrun, keeps stored value.
// RULE_17: Both bytes read: hidden overrun copied to visible bit, then cleared.
// RULE_18: Four channel mode: period storage is channel one on first pin.
// RULE_19: Count byte writes load at once; period writes work in both modes.

module tcu_top
   import tcu_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic [3:0]  snap_input_pin,
   input  wire logic        external_count_clock,
   output logic             irq
);

   tcu_state_s st_q;
   tcu_state_s s;
   logic       icyc;
   logic       efall;
   logic       tick;
   logic       wr_fire;
   logic       rd_fire;
   logic       limit_hit;
   logic [3:0] snap_ev;
   logic [3:0] snap_ok;
   logic [3:0] pair_done;

   tcu_tick_gen u_tick (
      .aclk                 (aclk),
      .aresetn              (aresetn),
      .external_count_clock (external_count_clock),
      .icyc                 (icyc),
      .efall                (efall)
   );

   for (genvar g = 0; g < 4; g++) begin : g_chan
      tcu_snap_chan u_chan (
         .aclk           (aclk),
         .aresetn        (aresetn),
         .snap_input_pin (snap_input_pin[g]),
         .edge_sel       (st_q.edge_sel[2*g +: 2]),
         .snap_event     (snap_ev[g])
      );
   end

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'h0) && (a <= `TCU_OFS_LAST);
   endfunction : is_mapped

   assign tick      = st_q.run & (st_q.src ? efall : icyc);        // see RULE_04
   // Period mode compares against channel one storage
   assign limit_hit = st_q.four ? (st_q.count == `TCU_CNT_MAX)      // see RULE_08
                                : (st_q.count == st_q.snap[0]);     // see RULE_05
   // Pins are read whatever their port role; channel one only in four mode
   assign snap_ok   = snap_ev & {3'b111, st_q.four};                // see RULE_07, RULE_14
   assign pair_done = st_q.lo_rd & st_q.hi_rd;
   assign wr_fire   = st_q.aw_held & st_q.w_held & ~st_q.bvalid;
   assign rd_fire   = st_q.arready & arvalid;

   always_comb begin
      s = st_q;

      // Write channels taken independently, response after both
      if (st_q.awready && awvalid) begin
         s.aw_held = 1'b1;
         s.aw_addr = awaddr;
         s.awready = 1'b0;
      end
      if (st_q.wready && wvalid) begin
         s.w_held = 1'b1;
         s.wbyte  = wdata[7:0];
         s.wstb   = wstrb[0];
         s.wready = 1'b0;
      end
      if (st_q.bvalid && bready) begin
         s.bvalid  = 1'b0;
         s.awready = 1'b1;
         s.wready  = 1'b1;
      end
      if (wr_fire) begin
         s.aw_held = 1'b0;
         s.w_held  = 1'b0;
         s.bvalid  = 1'b1;
         s.bresp   = is_mapped(st_q.aw_addr) ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
      end

      // Completed pair reads move the overrun to the visible bit
      for (int i = 0; i < 4; i++) begin
         if (pair_done[i]) begin
            s.ovf_v[i] = st_q.ovf_m[i];                             // see RULE_17
            s.ovf_m[i] = 1'b0;
            s.full[i]  = 1'b0;
            s.lo_rd[i] = 1'b0;
            s.hi_rd[i] = 1'b0;
         end
      end

      // Read channel, with read side effects
      if (st_q.rvalid && rready) begin
         s.rvalid  = 1'b0;
         s.arready = 1'b1;
      end
      if (rd_fire) begin
         s.arready = 1'b0;
         s.rvalid  = 1'b1;
         s.rdata   = 32'h0000_0000;
         s.rresp   = is_mapped(araddr) ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
         case (araddr)
            `TCU_OFS_CNT_LO: s.rdata[7:0] = st_q.count[7:0];       // see RULE_01
            `TCU_OFS_CNT_HI: s.rdata[7:0] = st_q.count[15:8];      // see RULE_01
            `TCU_OFS_CTRL: begin
               s.rdata[`TCU_CTRL_RUN]  = st_q.run;
               s.rdata[`TCU_CTRL_SRC]  = st_q.src;
               s.rdata[`TCU_CTRL_MODE] = st_q.four;
            end
            `TCU_OFS_STAT: begin
               s.rdata[`TCU_STAT_WRAP]     = st_q.wrap_flag;
               s.rdata[`TCU_STAT_SNAP +: 4] = st_q.snap_flag;
               // Clear on read; events below still win this cycle
               s.wrap_flag = 1'b0;                                  // see RULE_09
               s.snap_flag = 4'h0;                                  // see RULE_12
            end
            `TCU_OFS_MASK: begin
               s.rdata[`TCU_STAT_WRAP]     = st_q.wrap_en;
               s.rdata[`TCU_STAT_SNAP +: 4] = st_q.snap_en;
            end
            `TCU_OFS_OVF:  s.rdata[3:0] = st_q.ovf_v;
            `TCU_OFS_IRQC: begin
               s.rdata[`TCU_IRQC_PE] = st_q.pe;
               s.rdata[`TCU_IRQC_GD] = st_q.gd;
            end
            `TCU_OFS_EDGE: s.rdata[7:0] = st_q.edge_sel;
            default:       s.rdata = 32'h0000_0000;
         endcase
         for (int i = 0; i < 4; i++) begin
            if (araddr == 8'(`TCU_OFS_SNAP_BASE + `TCU_SNAP_STRIDE * i)) begin
               s.rdata[7:0] = st_q.snap[i][7:0];
               s.lo_rd[i]   = 1'b1;                                 // see RULE_17
            end
            if (araddr == 8'(`TCU_OFS_SNAP_BASE + `TCU_SNAP_STRIDE * i
                             + `TCU_SNAP_HI_OFS)) begin
               s.rdata[7:0] = st_q.snap[i][15:8];
               s.hi_rd[i]   = 1'b1;                                 // see RULE_17
            end
         end
      end

      // Counter step
      if (tick) begin
         if (limit_hit) begin
            s.count     = `TCU_CNT_ZERO;                            // see RULE_06
            s.wrap_flag = 1'b1;                                     // see RULE_08
         end else begin
            s.count = st_q.count + 16'h0001;                        // see RULE_01
         end
      end

      // Captures
      for (int i = 0; i < 4; i++) begin
         if (snap_ok[i]) begin                                      // see RULE_18
            if (s.full[i]) begin
               s.ovf_m[i] = 1'b1;                                   // see RULE_16
            end else begin
               s.snap[i]      = st_q.count;                         // see RULE_10
               s.full[i]      = 1'b1;
               s.snap_flag[i] = 1'b1;                               // see RULE_12
            end
         end
      end

      // Register writes, byte lane 0 only
      if (wr_fire && st_q.wstb) begin
         case (st_q.aw_addr)
            `TCU_OFS_CNT_LO: s.count[7:0]  = st_q.wbyte;            // see RULE_19
            `TCU_OFS_CNT_HI: s.count[15:8] = st_q.wbyte;            // see RULE_19
            `TCU_OFS_SNAP_BASE: s.snap[0][7:0] = st_q.wbyte;        // see RULE_19
            8'(`TCU_OFS_SNAP_BASE + `TCU_SNAP_HI_OFS): begin
               s.snap[0][15:8] = st_q.wbyte;                        // see RULE_19
            end
            `TCU_OFS_CTRL: begin
               s.run  = st_q.wbyte[`TCU_CTRL_RUN];                  // see RULE_04
               s.src  = st_q.wbyte[`TCU_CTRL_SRC];                  // see RULE_02
               s.four = st_q.wbyte[`TCU_CTRL_MODE];                 // see RULE_05
            end
            `TCU_OFS_MASK: begin
               s.wrap_en = st_q.wbyte[`TCU_STAT_WRAP];              // see RULE_09
               s.snap_en = st_q.wbyte[`TCU_STAT_SNAP +: 4];
            end
            `TCU_OFS_IRQC: begin
               s.pe = st_q.wbyte[`TCU_IRQC_PE];
               s.gd = st_q.wbyte[`TCU_IRQC_GD];
            end
            `TCU_OFS_EDGE: s.edge_sel = st_q.wbyte;                 // see RULE_13
            default: s.edge_sel = s.edge_sel;
         endcase
      end

      s.irq = (s.wrap_flag & s.wrap_en)                             // see RULE_09
            | ((|(s.snap_flag & s.snap_en)) & s.pe & ~s.gd);        // see RULE_12
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q         <= '0;
         st_q.awready <= 1'b1;
         st_q.wready  <= 1'b1;
         st_q.arready <= 1'b1;
      end else begin
         st_q <= s;
      end
   end

   assign awready = st_q.awready;
   assign wready  = st_q.wready;
   assign bresp   = st_q.bresp;
   assign bvalid  = st_q.bvalid;
   assign arready = st_q.arready;
   assign rdata   = st_q.rdata;
   assign rresp   = st_q.rresp;
   assign rvalid  = st_q.rvalid;
   assign irq     = st_q.irq;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_count_hold: assert property ( // see RULE_04
      (!st_q.run && !wr_fire) |=> $stable(st_q.count) && !$rose(st_q.wrap_flag))
      else $error("counter moved while stopped");

   a_period_wrap: assert property ( // see RULE_06
      (tick && !st_q.four && st_q.count == st_q.snap[0] && !wr_fire)
      |=> st_q.count == 16'h0000 && st_q.wrap_flag)
      else $error("period match did not wrap to zero");

   a_free_wrap: assert property ( // see RULE_08
      (tick && st_q.four && st_q.count == 16'hFFFF && !wr_fire)
      |=> st_q.count == 16'h0000 && st_q.wrap_flag)
      else $error("free run did not wrap at all ones");

   a_flag_sticky: assert property ( // see RULE_09
      (st_q.wrap_flag && !(rd_fire && araddr == `TCU_OFS_STAT)) |=> st_q.wrap_flag)
      else $error("wrap flag dropped without a status read");

   a_chan1_idle: assert property ( // see RULE_07
      (!st_q.four && !st_q.snap_flag[0]) |=> !st_q.snap_flag[0])
      else $error("channel one flagged in period mode");

   a_irq_cause: assert property ( // see RULE_12
      st_q.irq == ((st_q.wrap_flag && st_q.wrap_en)
                   || ((|(st_q.snap_flag & st_q.snap_en)) && st_q.pe && !st_q.gd)))
      else $error("interrupt level does not match its causes");

   a_count_step: assert property ( // see RULE_01
      (tick && !limit_hit && !wr_fire)
      |=> st_q.count == 16'($past(st_q.count) + 16'h0001))
      else $error("counter did not step by one");

   a_ext_only: assert property ( // see RULE_03
      (st_q.run && st_q.src && !efall && !wr_fire) |=> $stable(st_q.count))
      else $error("external source counted without a falling edge");

   a_icyc_only: assert property ( // see RULE_02
      (st_q.run && !st_q.src && !icyc && !wr_fire) |=> $stable(st_q.count))
      else $error("instruction source counted off its tick");

   a_snap_sticky: assert property ( // see RULE_12
      !(rd_fire && araddr == `TCU_OFS_STAT)
      |=> (st_q.snap_flag & $past(st_q.snap_flag)) == $past(st_q.snap_flag))
      else $error("capture flag dropped without a status read");

   a_irq_gated: assert property ( // see RULE_12
      ((st_q.gd || !st_q.pe) && !(st_q.wrap_flag && st_q.wrap_en)) |-> !st_q.irq)
      else $error("capture interrupt passed a closed gate");

   a_bresp_hold: assert property ( // see RULE_19
      (st_q.bvalid && !bready) |=> st_q.bvalid && $stable(st_q.bresp))
      else $error("write response withdrawn before it was taken");

   a_rdata_hold: assert property ( // see RULE_01
      (st_q.rvalid && !rready) |=> st_q.rvalid && $stable(st_q.rdata))
      else $error("read data withdrawn before it was taken");

   for (genvar g = 0; g < 4; g++) begin : g_chk
      a_snap_copy: assert property ( // see RULE_10
         (snap_ok[g] && (!st_q.full[g] || pair_done[g]) && !wr_fire)
         |=> st_q.snap[g] == $past(st_q.count) && st_q.snap_flag[g])
         else $error("capture did not copy the count");

      a_overrun_keep: assert property ( // see RULE_16
         (snap_ok[g] && st_q.full[g] && !pair_done[g] && !wr_fire)
         |=> $stable(st_q.snap[g]) && st_q.ovf_m[g])
         else $error("overrun overwrote an unread capture");

      a_ovf_move: assert property ( // see RULE_17
         pair_done[g] |=> st_q.ovf_v[g] == $past(st_q.ovf_m[g]) && !st_q.lo_rd[g])
         else $error("overrun not moved after both bytes read");

      a_ovf_sticky: assert property ( // see RULE_16
         (st_q.ovf_m[g] && !pair_done[g]) |=> st_q.ovf_m[g])
         else $error("hidden overrun lost before the pair was read");
   end

endmodule : tcu_top

// ### shared/tcu_defs.svh
`ifndef TCU_DEFS_SVH
`define TCU_DEFS_SVH

// Register byte offsets, one aligned 32-bit word each, data in bits 7:0
`define TCU_OFS_CNT_LO      8'h00
`define TCU_OFS_CNT_HI      8'h04
`define TCU_OFS_SNAP_BASE   8'h08
`define TCU_SNAP_STRIDE     8'h08
`define TCU_SNAP_HI_OFS     8'h04
`define TCU_OFS_CTRL        8'h28
`define TCU_OFS_STAT        8'h2C
`define TCU_OFS_MASK        8'h30
`define TCU_OFS_OVF         8'h34
`define TCU_OFS_IRQC        8'h38
`define TCU_OFS_EDGE        8'h3C
`define TCU_OFS_LAST        8'h3C

// Field positions
`define TCU_CTRL_RUN        0
`define TCU_CTRL_SRC        1
`define TCU_CTRL_MODE       2
`define TCU_STAT_WRAP       0
`define TCU_STAT_SNAP       1
`define TCU_IRQC_PE         0
`define TCU_IRQC_GD         1

// Edge select encodings
`define TCU_EDGE_FALL       2'h0
`define TCU_EDGE_RISE       2'h1
`define TCU_EDGE_4TH        2'h2
`define TCU_EDGE_16TH       2'h3
`define TCU_PSC_4TH_LAST    2'h3
`define TCU_PSC_16TH_LAST   4'hF

// Timing: instruction cycle is four core clocks
`define TCU_ICYC_LAST       2'h3
`define TCU_CNT_MAX         16'hFFFF
`define TCU_CNT_ZERO        16'h0000

// AXI responses
`define TCU_RESP_OKAY       2'h0
`define TCU_RESP_SLVERR     2'h2

`endif

// ### shared/tcu_pkg.sv
package tcu_pkg;

   typedef logic [15:0] tcu_word_t;

   typedef struct packed {
      logic [1:0] phase;
      logic       ext_s1;
      logic       ext_s2;
      logic       ext_prev;
      logic       icyc;
      logic       efall;
   } tcu_tick_s;

   typedef struct packed {
      logic       pin_s1;
      logic       pin_s2;
      logic       pin_prev;
      logic [3:0] psc;
      logic       ev;
   } tcu_chan_s;

   typedef struct packed {
      tcu_word_t             count;
      tcu_word_t [3:0]       snap;
      logic [3:0]            full;
      logic [3:0]            lo_rd;
      logic [3:0]            hi_rd;
      logic [3:0]            ovf_m;
      logic [3:0]            ovf_v;
      logic [3:0]            snap_flag;
      logic [3:0]            snap_en;
      logic [7:0]            edge_sel;
      logic                  run;
      logic                  src;
      logic                  four;
      logic                  wrap_flag;
      logic                  wrap_en;
      logic                  pe;
      logic                  gd;
      logic                  irq;
      logic                  awready;
      logic                  wready;
      logic                  aw_held;
      logic                  w_held;
      logic                  bvalid;
      logic                  arready;
      logic                  rvalid;
      logic [7:0]            aw_addr;
      logic [7:0]            wbyte;
      logic                  wstb;
      logic [1:0]            bresp;
      logic [1:0]            rresp;
      logic [31:0]           rdata;
   } tcu_state_s;

endpackage : tcu_pkg
